// ---- core/periph_select_flow_ctrl_pin_mux.sv ----
// module: shared-pin mux for peripheral selects two/three/five/six, port 1 flow control, pio
//
// How it works
// - select two/three only without flow control
// - each select decodes one 256-byte region
// - peripheral select suppresses overlapping dram access
// - selects assert with multiplexed address phase
// - selects float high in hold, reset
// - pin is clear-to-send when receive-select zero
// - pending frame starts only while clear-to-send
// - clear-to-send sampled only at frame start
// - receive-select one: pin gates port receiver
// - ready-to-send while transmit data pending
// - ready-to-receive while receive register empty
// - extended-select zero: pins give address bits
// - latched address bits hold during bus hold
// - 32 pins with enable, direction, pull
// - most pins reset to pio input pullup
// - address, direction, enable, ready stay normal
`timescale 1ns/10ps
`default_nettype none
module periph_select_flow_ctrl_pin_mux (
  input  wire logic        SYS_CLK,
  input  wire logic        RST_B,
  input  wire logic        CLK_EN,
  // bus unit side
  input  wire logic        ADDR_PHASE,          // multiplexed address phase strobe
  input  wire logic [19:0] BUS_ADDR,
  input  wire logic        BUS_IO_SPACE,        // one = io space cycle
  input  wire logic        PERIPH_MEM_SPACE,    // one = peripheral block lives in memory space
  input  wire logic [11:0] PERIPH_BASE,         // base, 1-Kbyte aligned (addr[19:10])
  input  wire logic        DRAM_REQ,            // bus unit wants a dram access this cycle
  input  wire logic        BUS_HOLD,            // hold acknowledged
  output logic             DRAM_GO,
  // configuration bits
  input  wire logic        FLOW_CONTROL_ENABLE,
  input  wire logic        RX_ENABLE_SELECT,    // one = receiver-enable request mode
  input  wire logic        SEND_REQUEST_SELECT, // one = ready-to-send mode
  input  wire logic        EXTENDED_SELECT_ENABLE,
  // serial port 1 side
  input  wire logic        TX_PENDING,          // transmit register holds untransmitted data
  input  wire logic        TX_IDLE,             // shifter idle, can start a frame
  output logic             TX_START,            // one-cycle pulse: load frame into shifter
  output logic             RX_GATE,             // receiver enabled
  input  wire logic        RX_FULL,             // receive register holds unread data
  // pio configuration
  input  wire logic        PIO_CFG_WE,
  input  wire logic [31:0] PIO_CFG_EN,
  input  wire logic [31:0] PIO_CFG_DIR,
  input  wire logic [31:0] PIO_CFG_PULLDN,
  input  wire logic [31:0] PIO_CFG_OUT,
  output logic      [31:0] PIO_IN,
  // pins
  input  wire logic [31:0] PIN_IN,
  output logic      [31:0] PIN_OUT,
  output logic      [31:0] PIN_OE,
  output logic      [31:0] PIN_PULLUP,
  output logic      [31:0] PIN_PULLDOWN,
  input  wire logic [31:0] NORMAL_OUT,          // normal-function drive for other shared pins
  input  wire logic [31:0] NORMAL_OE
);
  typedef enum logic [2:0] {
    TX_WAIT  = 3'b001,
    TX_CHECK = 3'b010,
    TX_BUSY  = 3'b100
  } tx_state_t;

  tx_state_t   tx_q;
  tx_state_t   tx_d;
  logic [31:0] pio_en;
  logic [31:0] pio_dir;
  logic [31:0] pio_pd;
  logic [31:0] pio_out;
  logic [31:0] pio_in_sync;
  logic [3:0]  sel_q;                // active-high selects: two, three, five, six
  logic [1:0]  addr_bits_q;          // latched address bits one, two
  logic        in_reset_q;
  logic        fc_cts;
  logic        fc_enrx;
  logic        peri_hit;
  logic [2:0]  region;
  logic        shared_in;

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // peripheral block hit: 7 regions of 256 bytes above the base
  function automatic logic block_hit(input logic [19:0] a, input logic [11:0] base);
    logic [19:0] off;
    off = a - {base[9:0], 10'h000};
    return (a >= {base[9:0], 10'h000}) &&
           (off[19:pin_mux_pkg::PERIPH_REGION_W] < 12'(pin_mux_pkg::PERIPH_REGIONS));
  endfunction : block_hit

  // ----------------------------------------
  // programmable io bank
  // ----------------------------------------
  pio_bank u_pio (
    .clk        (SYS_CLK),
    .rst_b      (RST_B),
    .ce         (CLK_EN),
    .cfg_we     (PIO_CFG_WE),
    .cfg_en     (PIO_CFG_EN),
    .cfg_dir    (PIO_CFG_DIR),
    .cfg_pulldn (PIO_CFG_PULLDN),
    .cfg_out    (PIO_CFG_OUT),
    .pin_in     (PIN_IN),
    .en_q       (pio_en),
    .dir_q      (pio_dir),
    .pulldn_q   (pio_pd),
    .out_q      (pio_out),
    .in_q       (pio_in_sync)
  );
  assign PIO_IN = pio_in_sync;

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  // a pin claimed as pio is unavailable for flow control
  assign fc_cts    = FLOW_CONTROL_ENABLE && !RX_ENABLE_SELECT && !pio_en[pin_mux_pkg::PIO_SEL_TWO];
  assign fc_enrx   = FLOW_CONTROL_ENABLE && RX_ENABLE_SELECT && !pio_en[pin_mux_pkg::PIO_SEL_TWO];
  assign shared_in = pio_in_sync[pin_mux_pkg::PIO_SEL_TWO];   // synchronised shared pin, active low
  // receiver runs freely unless the pin serves as receiver-enable request
  assign RX_GATE   = !fc_enrx || !shared_in;

  // ----------------------------------------
  // peripheral select decode
  // ----------------------------------------
  assign region   = 3'((BUS_ADDR - {PERIPH_BASE[9:0], 10'h000}) >> pin_mux_pkg::PERIPH_REGION_W);
  assign peri_hit = block_hit(BUS_ADDR, PERIPH_BASE) && (BUS_IO_SPACE != PERIPH_MEM_SPACE);
  // peripheral wins an overlap; dram waits out the cycle
  assign DRAM_GO  = DRAM_REQ && !(peri_hit && !BUS_IO_SPACE);

  // selects register on the address phase and hold until the next one
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sel_q <= 4'h0;
    end else if (CLK_EN && ADDR_PHASE) begin
      sel_q[0] <= peri_hit && (region == pin_mux_pkg::REGION_TWO);
      sel_q[1] <= peri_hit && (region == pin_mux_pkg::REGION_THREE);
      sel_q[2] <= peri_hit && (region == pin_mux_pkg::REGION_FIVE);
      sel_q[3] <= peri_hit && (region == pin_mux_pkg::REGION_SIX);
    end
  end

  // latched address bits: frozen in hold so the pins never float
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      addr_bits_q <= 2'h0;
    end else if (CLK_EN && ADDR_PHASE && !BUS_HOLD) begin
      addr_bits_q <= BUS_ADDR[2:1];
    end
  end

  // reset flag lets pulls stay on for the first cycle after release
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      in_reset_q <= 1'b1;
    end else if (CLK_EN) begin
      in_reset_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // port 1 transmit gate
  // ----------------------------------------
  // clear-to-send looked at once per frame; later changes are ignored
  always_comb begin
    tx_d = tx_q;
    unique case (tx_q)
      TX_WAIT:  if (TX_PENDING && TX_IDLE) begin
                  tx_d = TX_CHECK;
                end
      TX_CHECK: if (!fc_cts || !shared_in) begin
                  tx_d = TX_BUSY;
                end
      TX_BUSY:  if (TX_IDLE && !TX_START) begin
                  tx_d = TX_WAIT;
                end
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_q <= TX_WAIT;
    end else if (CLK_EN) begin
      tx_q <= tx_d;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      TX_START <= 1'b0;
    end else if (CLK_EN) begin
      TX_START <= (tx_q == TX_CHECK) && (tx_d == TX_BUSY);
    end else begin
      TX_START <= 1'b0;
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  always_comb begin
    PIN_OUT      = NORMAL_OUT;
    PIN_OE       = NORMAL_OE;
    PIN_PULLUP   = 32'h0000_0000;
    PIN_PULLDOWN = 32'h0000_0000;
    // select two / clear-to-send / receiver request
    PIN_OUT[pin_mux_pkg::PIO_SEL_TWO]   = !sel_q[0];
    PIN_OE[pin_mux_pkg::PIO_SEL_TWO]    = !FLOW_CONTROL_ENABLE && !BUS_HOLD;
    // select three / ready-to-send / ready-to-receive, all active low
    PIN_OUT[pin_mux_pkg::PIO_SEL_THREE] = FLOW_CONTROL_ENABLE ?
                                          (SEND_REQUEST_SELECT ? !TX_PENDING : RX_FULL) : !sel_q[1];
    PIN_OE[pin_mux_pkg::PIO_SEL_THREE]  = FLOW_CONTROL_ENABLE || !BUS_HOLD;
    // selects five/six or latched address bits one/two
    PIN_OUT[pin_mux_pkg::PIO_SEL_FIVE]  = EXTENDED_SELECT_ENABLE ? !sel_q[2] : addr_bits_q[0];
    PIN_OUT[pin_mux_pkg::PIO_SEL_SIX]   = EXTENDED_SELECT_ENABLE ? !sel_q[3] : addr_bits_q[1];
    PIN_OE[pin_mux_pkg::PIO_SEL_FIVE]   = !EXTENDED_SELECT_ENABLE || !BUS_HOLD;
    PIN_OE[pin_mux_pkg::PIO_SEL_SIX]    = !EXTENDED_SELECT_ENABLE || !BUS_HOLD;
    // weak pull-ups hold floated selects high in hold and reset
    PIN_PULLUP[pin_mux_pkg::PIO_SEL_TWO]   = BUS_HOLD || in_reset_q;
    PIN_PULLUP[pin_mux_pkg::PIO_SEL_THREE] = BUS_HOLD || in_reset_q;
    PIN_PULLUP[pin_mux_pkg::PIO_SEL_FIVE]  = (EXTENDED_SELECT_ENABLE && BUS_HOLD) || in_reset_q;
    PIN_PULLUP[pin_mux_pkg::PIO_SEL_SIX]   = (EXTENDED_SELECT_ENABLE && BUS_HOLD) || in_reset_q;
    // pio overrides: drive when set as output, pulls per config
    for (int i = 0; i < 32; i++) begin
      if (pio_en[i]) begin
        PIN_OUT[i]      = pio_out[i];
        PIN_OE[i]       = !pio_dir[i];
        PIN_PULLUP[i]   = !pio_pd[i];
        PIN_PULLDOWN[i] = pio_pd[i];
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // internal state is watched where the pins alone cannot tell the modes apart
  AST_SEL_TWO_FC: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (FLOW_CONTROL_ENABLE && !pio_en[18]) |-> !PIN_OE[18])
    else $error("select two driven while flow control on");
  AST_SEL_TWO_DRIVE: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (!FLOW_CONTROL_ENABLE && !BUS_HOLD && !pio_en[18]) |-> (PIN_OE[18] && PIN_OUT[18] == !sel_q[0]))
    else $error("select two not driven without flow control");
  AST_SEL_MISS: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (CLK_EN && ADDR_PHASE && !peri_hit) |=> (sel_q == 4'h0))
    else $error("select asserted outside the peripheral block");
  AST_DRAM_SUPPRESS: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (peri_hit && !BUS_IO_SPACE) |-> !DRAM_GO)
    else $error("dram went ahead over peripheral select");
  AST_DRAM_PASS: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (DRAM_REQ && !peri_hit) |-> DRAM_GO)
    else $error("dram held back without a select");
  AST_SEL_PHASE: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (CLK_EN && !ADDR_PHASE) |=> $stable(sel_q))
    else $error("select changed outside address phase");
  AST_HOLD_FLOAT: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (BUS_HOLD && !FLOW_CONTROL_ENABLE && !pio_en[18]) |-> (!PIN_OE[18] && PIN_PULLUP[18]))
    else $error("select two not floated high in hold");
  AST_RESET_PULL: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    in_reset_q |-> (PIN_PULLUP[18] && PIN_PULLUP[19]))
    else $error("select pullups off just after reset");
  AST_CTS_HOLDS: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (CLK_EN && tx_q == TX_CHECK && fc_cts && shared_in) |=> (tx_q == TX_CHECK && !TX_START))
    else $error("frame started without clear-to-send");
  AST_TX_PULSE: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    TX_START |=> !TX_START)
    else $error("frame start longer than one cycle");
  AST_CTS_ONCE: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (CLK_EN && tx_q == TX_BUSY && !TX_IDLE) |=> (tx_q == TX_BUSY))
    else $error("running frame disturbed");
  AST_RX_GATED: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (FLOW_CONTROL_ENABLE && RX_ENABLE_SELECT && !pio_en[18] && pio_in_sync[18]) |-> !RX_GATE)
    else $error("receiver on without request");
  AST_RX_OPEN: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    !(FLOW_CONTROL_ENABLE && RX_ENABLE_SELECT) |-> RX_GATE)
    else $error("receiver gated outside request mode");
  AST_RTS: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (FLOW_CONTROL_ENABLE && SEND_REQUEST_SELECT && !pio_en[19]) |-> (PIN_OUT[19] == !TX_PENDING))
    else $error("ready-to-send wrong");
  AST_RTR: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (FLOW_CONTROL_ENABLE && !SEND_REQUEST_SELECT && !pio_en[19]) |-> (PIN_OUT[19] == RX_FULL))
    else $error("ready-to-receive wrong");
  AST_ADDR_OUT: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (!EXTENDED_SELECT_ENABLE && !pio_en[3]) |-> (PIN_OE[3] && PIN_OUT[3] == addr_bits_q[0]))
    else $error("address bit one not on its pin");
  AST_ADDR_HOLD: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    BUS_HOLD |=> $stable(addr_bits_q))
    else $error("latched address moved in hold");
  AST_PIO_PULL: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (pio_en[1] && pio_pd[1]) |-> (PIN_PULLDOWN[1] && !PIN_PULLUP[1]))
    else $error("pio pull selection not applied");
  AST_PIO_WINS: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    pio_en[3] |-> (PIN_OUT[3] == pio_out[3] && PIN_OE[3] == !pio_dir[3]))
    else $error("pio not overriding shared pin");
endmodule : periph_select_flow_ctrl_pin_mux
`default_nettype wire

// ---- core/pin_mux_pkg.sv ----
// package: constants for the peripheral select / flow control / programmable io pin mux
package pin_mux_pkg;
  localparam int unsigned PIO_COUNT        = 32;
  localparam int unsigned PERIPH_REGION_W  = 8;                 // 256-byte region per select
  localparam int unsigned PERIPH_REGIONS   = 7;                 // regions zero..six
  localparam logic [2:0]  REGION_TWO       = 3'h2;
  localparam logic [2:0]  REGION_THREE     = 3'h3;
  localparam logic [2:0]  REGION_FIVE      = 3'h5;
  localparam logic [2:0]  REGION_SIX       = 3'h6;
  // pio pin numbers of the shared pins handled here
  localparam int unsigned PIO_SEL_SIX      = 2;
  localparam int unsigned PIO_SEL_FIVE     = 3;
  localparam int unsigned PIO_SEL_TWO      = 18;
  localparam int unsigned PIO_SEL_THREE    = 19;
  // power-on defaults: one = pio function enabled (input with pull)
  localparam logic [31:0] PIO_EN_RESET     = 32'hFFFF_FC0F;     // pins 4..9 keep normal function
  localparam logic [31:0] PIO_DIR_RESET    = 32'hFFFF_FFFF;     // one = input
  localparam logic [31:0] PIO_PULLDN_RESET = 32'h0000_0402;     // pins 1 and 10 pull down
  localparam logic [31:0] PIO_OUT_RESET    = 32'h0000_0000;
endpackage : pin_mux_pkg

// ---- core/pio_bank.sv ----
// module: programmable io bank, per-pin enable, direction, pull select, output data
`timescale 1ns/10ps
`default_nettype none
module pio_bank (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        cfg_we,
  input  wire logic [31:0] cfg_en,
  input  wire logic [31:0] cfg_dir,
  input  wire logic [31:0] cfg_pulldn,
  input  wire logic [31:0] cfg_out,
  input  wire logic [31:0] pin_in,
  output logic      [31:0] en_q,
  output logic      [31:0] dir_q,
  output logic      [31:0] pulldn_q,
  output logic      [31:0] out_q,
  output logic      [31:0] in_q
);
  logic [31:0] in_meta_q;

  // ----------------------------------------
  // configuration: power-on defaults, then software
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_q     <= pin_mux_pkg::PIO_EN_RESET;
      dir_q    <= pin_mux_pkg::PIO_DIR_RESET;
      pulldn_q <= pin_mux_pkg::PIO_PULLDN_RESET;
      out_q    <= pin_mux_pkg::PIO_OUT_RESET;
    end else if (ce && cfg_we) begin
      en_q     <= cfg_en;
      dir_q    <= cfg_dir;
      pulldn_q <= cfg_pulldn;
      out_q    <= cfg_out;
    end
  end

  // ----------------------------------------
  // pin inputs are asynchronous: two flops
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      in_meta_q <= 32'h0000_0000;
      in_q      <= 32'h0000_0000;
    end else if (ce) begin
      in_meta_q <= pin_in;
      in_q      <= in_meta_q;
    end
  end
endmodule : pio_bank
`default_nettype wire

// ---- tb/flow_partner.sv ----
// far-side model: serial flow partner and pin resolution for the shared pins
`timescale 1ns/10ps
`default_nettype none
module flow_partner (
  input  wire logic        clk,
  input  wire logic        cts_on,
  input  wire logic        cts_assert,
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  input  wire logic [31:0] pin_pullup,
  input  wire logic [31:0] pin_pulldown,
  output logic      [31:0] pin_in
);
  logic [31:0] flip_q = 32'h5555_5555;
  // undriven, unpulled pins wander so a stale value never passes for a real one
  always_ff @(posedge clk) begin
    flip_q <= ~flip_q;
  end
  // wire level: our drive first, then the partner's handshake line, then the pulls
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (i == 18 && cts_on) begin
        pin_in[i] = ~cts_assert; // handshake line is active low
      end else if (pin_pullup[i]) begin
        pin_in[i] = 1'b1;
      end else if (pin_pulldown[i]) begin
        pin_in[i] = 1'b0;
      end else begin
        pin_in[i] = flip_q[i];
      end
    end
  end
endmodule : flow_partner
`default_nettype wire

// ---- tb/tb.sv ----
// testbench: shared-pin mux for peripheral selects, port 1 flow control and pio
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic SYS_CLK = 1'b0, RST_B = 1'b0, ADDR_PHASE = 1'b0, BUS_IO_SPACE = 1'b0, PERIPH_MEM_SPACE = 1'b1;
  logic DRAM_REQ = 1'b1, BUS_HOLD = 1'b0, FLOW_CONTROL_ENABLE = 1'b0, RX_ENABLE_SELECT = 1'b0;
  logic SEND_REQUEST_SELECT = 1'b1, EXTENDED_SELECT_ENABLE = 1'b1, TX_PENDING = 1'b0, TX_IDLE = 1'b1;
  logic RX_FULL = 1'b0, PIO_CFG_WE = 1'b0, cts_on = 1'b0, cts_assert = 1'b0, CLK_EN = 1'b1;
  logic [19:0] BUS_ADDR = 20'h00000;
  logic [11:0] PERIPH_BASE = 12'h040; // peripheral block at 10000h
  logic [31:0] PIO_CFG_EN = 32'h0, PIO_CFG_DIR = 32'hFFFF_FFFF, PIO_CFG_PULLDN = 32'h0, PIO_CFG_OUT = 32'h0;
  logic [31:0] PIN_IN, PIN_OUT, PIN_OE, PIN_PULLUP, PIN_PULLDOWN, PIO_IN;
  logic DRAM_GO, TX_START, RX_GATE;
  int errors = 0, checked = 0, starts = 0, cyc = 0;
  always #12.5 SYS_CLK = ~SYS_CLK;
  periph_select_flow_ctrl_pin_mux dut_u (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .CLK_EN(CLK_EN),
    .ADDR_PHASE(ADDR_PHASE), .BUS_ADDR(BUS_ADDR), .BUS_IO_SPACE(BUS_IO_SPACE),
    .PERIPH_MEM_SPACE(PERIPH_MEM_SPACE), .PERIPH_BASE(PERIPH_BASE), .DRAM_REQ(DRAM_REQ),
    .BUS_HOLD(BUS_HOLD), .DRAM_GO(DRAM_GO), .FLOW_CONTROL_ENABLE(FLOW_CONTROL_ENABLE),
    .RX_ENABLE_SELECT(RX_ENABLE_SELECT), .SEND_REQUEST_SELECT(SEND_REQUEST_SELECT),
    .EXTENDED_SELECT_ENABLE(EXTENDED_SELECT_ENABLE), .TX_PENDING(TX_PENDING), .TX_IDLE(TX_IDLE),
    .TX_START(TX_START), .RX_GATE(RX_GATE), .RX_FULL(RX_FULL), .PIO_CFG_WE(PIO_CFG_WE),
    .PIO_CFG_EN(PIO_CFG_EN), .PIO_CFG_DIR(PIO_CFG_DIR), .PIO_CFG_PULLDN(PIO_CFG_PULLDN),
    .PIO_CFG_OUT(PIO_CFG_OUT), .PIO_IN(PIO_IN), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
    .PIN_PULLUP(PIN_PULLUP), .PIN_PULLDOWN(PIN_PULLDOWN), .NORMAL_OUT(32'hA5A5_A5A5),
    .NORMAL_OE(32'hFFFF_FFFF));
  flow_partner partner_u (.clk(SYS_CLK), .cts_on(cts_on), .cts_assert(cts_assert), .pin_out(PIN_OUT),
    .pin_oe(PIN_OE), .pin_pullup(PIN_PULLUP), .pin_pulldown(PIN_PULLDOWN), .pin_in(PIN_IN));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // frame starts are counted on the sampling edge, so a one-cycle pulse is never missed
  always @(posedge SYS_CLK) begin
    cyc++;
    if (TX_START === 1'b1) starts++;
    if (cyc == 4000) begin
      errors++;
      $display("[FAIL] %0t run did not finish in time", $time);
      summarize();
    end
  end
  task automatic summarize();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic pio_wr(input logic [31:0] en, input logic [31:0] dir, input logic [31:0] out);
    @(negedge SYS_CLK);
    {PIO_CFG_WE, PIO_CFG_EN, PIO_CFG_DIR, PIO_CFG_OUT} = {1'b1, en, dir, out};
    PIO_CFG_PULLDN = pin_mux_pkg::PIO_PULLDN_RESET;
    @(negedge SYS_CLK);
    PIO_CFG_WE = 1'b0;
    @(negedge SYS_CLK);
  endtask : pio_wr
  // one address phase; the selects stand until the next one
  // dram go is checked in the address phase: held back only for memory-space cycles into the block
  task automatic bus_cycle(input logic [19:0] addr, input logic io);
    @(negedge SYS_CLK);
    {ADDR_PHASE, BUS_ADDR, BUS_IO_SPACE} = {1'b1, addr, io};
    #1 chk(32'(DRAM_GO), 32'(!(PERIPH_MEM_SPACE && !io && addr[19:16] == 4'h1 && addr[15:8] < 8'h07)), "dram go");
    @(negedge SYS_CLK);
    ADDR_PHASE = 1'b0;
    @(negedge SYS_CLK);
  endtask : bus_cycle
  function automatic logic [31:0] sel4();
    return 32'({PIN_OUT[2], PIN_OUT[3], PIN_OUT[19], PIN_OUT[18]});
  endfunction : sel4
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    static logic [3:0] exp_sel [5] = '{4'hE, 4'hD, 4'hB, 4'h7, 4'hF};
    static logic [19:0] adr [5] = '{20'h10210, 20'h10310, 20'h10510, 20'h10610, 20'h20210};
    repeat (16) @(negedge SYS_CLK);
    chk(PIN_PULLUP, 32'hFFFF_F80D, "reset pullups");
    chk(PIN_PULLDOWN, 32'h0000_0402, "reset pulldowns");
    chk(PIN_OE, 32'h0000_03F0, "reset drive");
    chk(PIN_OUT & 32'h3F0, 32'h0000_01A0, "normal pins pass");
    RST_B = 1'b1;
    $display("test reset done");
    // shared select pins and the dram strobe pins go back to normal before dram use
    pio_wr(pin_mux_pkg::PIO_EN_RESET & ~32'h030C_800C, 32'hFFFF_FFFF, 32'h0);
    for (int i = 0; i < 5; i++) begin
      bus_cycle(adr[i], 1'b0);
      chk(sel4(), 32'(exp_sel[i]), "select decode");
      chk(32'(PIN_OE[19:18]), 32'h3, "select drive");
    end
    bus_cycle(20'h10250, 1'b0);
    @(negedge SYS_CLK) BUS_ADDR = 20'h10610;
    repeat (2) @(negedge SYS_CLK);
    chk(sel4(), 32'hE, "select holds between phases");
    PERIPH_MEM_SPACE = 1'b0;
    bus_cycle(20'h10310, 1'b1);
    chk(sel4(), 32'hD, "io space select");
    bus_cycle(20'h10310, 1'b0);
    chk(sel4(), 32'hF, "memory cycle to io block");
    PERIPH_MEM_SPACE = 1'b1;
    CLK_EN = 1'b0;
    bus_cycle(20'h10210, 1'b0);
    chk(sel4(), 32'hF, "selects frozen while clock enable low");
    CLK_EN = 1'b1;
    BUS_HOLD = 1'b1;
    @(negedge SYS_CLK);
    chk(PIN_OE & 32'h000C_000C, 32'h0, "selects float in hold");
    chk(PIN_PULLUP & 32'h000C_000C, 32'h000C_000C, "selects pulled high in hold");
    BUS_HOLD = 1'b0;
    $display("test selects done");
    EXTENDED_SELECT_ENABLE = 1'b0;
    bus_cycle(20'h00002, 1'b0);
    chk(32'(PIN_OUT[3:2]), 32'h2, "address bits");
    BUS_HOLD = 1'b1;
    bus_cycle(20'h00004, 1'b0);
    chk(32'(PIN_OUT[3:2]), 32'h2, "address bits kept in hold");
    chk(32'(PIN_OE[3:2]), 32'h3, "address bits driven in hold");
    BUS_HOLD = 1'b0;
    $display("test address bits done");
    @(negedge SYS_CLK);
    {FLOW_CONTROL_ENABLE, cts_on, cts_assert, TX_PENDING, TX_IDLE} = 5'b11011;
    repeat (12) @(negedge SYS_CLK);
    chk(32'(starts), 32'h0, "frame held without clear to send");
    chk(32'(PIN_OE[18]), 32'h0, "select two off under flow control");
    chk(32'(PIN_OUT[19]), 32'h0, "ready to send while pending");
    cts_assert = 1'b1;
    for (int i = 0; i < 10 && starts == 0; i++) @(negedge SYS_CLK);
    chk(32'(starts), 32'h1, "frame starts on clear to send");
    TX_IDLE = 1'b0;
    repeat (3) @(negedge SYS_CLK) cts_assert = ~cts_assert;
    repeat (8) @(negedge SYS_CLK);
    chk(32'(starts), 32'h1, "mid-frame changes ignored");
    TX_PENDING = 1'b0;
    @(negedge SYS_CLK);
    chk(32'(PIN_OUT[19]), 32'h1, "ready to send drops");
    SEND_REQUEST_SELECT = 1'b0;
    @(negedge SYS_CLK);
    chk(32'(PIN_OUT[19]), 32'h0, "ready to receive while empty");
    RX_FULL = 1'b1;
    @(negedge SYS_CLK);
    chk(32'(PIN_OUT[19]), 32'h1, "ready to receive drops when full");
    {RX_ENABLE_SELECT, cts_assert} = 2'b11;
    repeat (5) @(negedge SYS_CLK);
    chk(32'(RX_GATE), 32'h1, "receiver enabled by request");
    cts_assert = 1'b0;
    repeat (5) @(negedge SYS_CLK);
    chk(32'(RX_GATE), 32'h0, "receiver gated off");
    $display("test flow control done");
    // pin 18 as a pio output driving low must beat the flow and select functions
    pio_wr((pin_mux_pkg::PIO_EN_RESET & ~32'h030C_800C) | 32'h0004_0000, 32'hFFFB_FFFF, 32'h0);
    chk(32'(PIN_OE[18]), 32'h1, "pio drives shared pin");
    chk(32'(PIN_OUT[18]), 32'h0, "pio value on shared pin");
    chk(PIO_IN & 32'h3, 32'h1, "pio inputs see pulls");
    $display("test pio override done");
    summarize();
  end
endmodule : tb
`default_nettype wire
